// file: hw/flash_status_defines.svh
// Purpose: offsets, command codes and timing counts of the flash status/reset sequencer
// Assumes: 250 MHz clock
// Notes: byte addresses on the Avalon-MM slave
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH

// register byte offsets
`define OFS_ADDR 5'h00
`define OFS_DATA 5'h04
`define OFS_STATE 5'h08

// command cycle addresses and data
`define CMD_ADDR_UNLOCK1 12'h555
`define CMD_ADDR_UNLOCK2 12'h2aa
`define CMD_UNLOCK1 8'haa
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_AUTOSELECT 8'h90
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hf0

// erased byte and autoselect code values
`define ERASED_BYTE 8'hff
`define AUTOSEL_CODE 8'h5a

// timing
`define CLK_PERIOD_NS 4
`define ERASE_WIN_US 50
`define ERASE_WIN_CYCLES ((`ERASE_WIN_US * 1000) / `CLK_PERIOD_NS)
`define RESET_TO_READ_NS 250
`define RESET_TO_READ_CYCLES (`RESET_TO_READ_NS / `CLK_PERIOD_NS)
`define PROG_CYCLES 64
`define ERASE_CYCLES 2048
`define LIMIT_CYCLES 1024
`define READY_BUSY_CYCLES 128
`define READY_IDLE_CYCLES 32

`endif

// file: hw/flash_status_pkg.sv
// Purpose: types of the flash status/reset sequencer
// Assumes: nothing
// Notes: one packed struct holds all state
package flash_status_pkg;

  typedef enum logic [3:0] {
    ST_READ, ST_C1, ST_C2, ST_PROG_ADDR, ST_E3, ST_E4, ST_E5, ST_AUTOSEL,
    ST_PROGRAM, ST_ERASE_WIN, ST_ERASE, ST_SUSP, ST_FAIL, ST_HWRST
  } state_e;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [11:0] addr;
    state_e st;
    logic susp;
    logic [7:0] pd;
    logic [3:0] pa;
    logic bad;
    logic tl;
    logic ew;
    logic [3:0] sel;
    logic [23:0] cnt;
    logic tog;
    logic stog;
    logic hw_busy;
    logic busy_oe_n;
    logic [15:0][7:0] mem;
  } state_s;

endpackage : flash_status_pkg

// file: hw/flash_write_status_and_reset_cmd.sv
// Purpose: program/erase status bits, busy pin and reset command of a small parallel flash
// Assumes: srst synchronous active high; reset_pin_n synchronous to clk
// Notes: 16-byte array in four 4-byte sectors; commands are writes to the DATA register
//
// Summary of operation
// - over pulse limit sets timing-limit flag
// - programming 0 to 1 halts, then flags
// - each added sector restarts erase window
// - window expiry sets erase-window flag
// - erase running: only suspend accepted
// - window open: more sector erases accepted
// - busy low during operations, program rejects commands
// - erase suspend releases busy pin
// - busy after fourth/sixth command strobe
// - hardware reset holds busy until done
// - program/erase status bit patterns
// - suspended sector status, elsewhere array
// - reset command returns, address ignored
// - reset aborts erase sequence before start
// - reset aborts program sequence before start
// - reset after failure returns to read, or to suspend if an erase is suspended
// - reset returns within 250 ns
// - poll bit shows complement while programming
// - toggle bit flips on each status read during program or erase
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "flash_status_defines.svh"

module flash_write_status_and_reset_cmd
  import flash_status_pkg::*;
#(
  parameter int ERASE_WIN_CYCLES = `ERASE_WIN_CYCLES
) (
  input wire logic clk, // 250 MHz clock
  input wire logic srst, // synchronous reset
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic reset_pin_n, // hardware reset pin
  output logic busy_indicator_n_o, // pin level when driven
  output logic busy_indicator_n_oe_n // low while pulling low
);

  state_s r_reg;
  state_s r_next;

  // sector of an array address
  function automatic logic [1:0] sector_of(input logic [11:0] a);
    sector_of = a[3:2];
  endfunction : sector_of

  // operation in progress states
  function automatic logic is_busy(input state_s s);
    is_busy = (s.st == ST_PROGRAM) || (s.st == ST_ERASE_WIN) || (s.st == ST_ERASE) ||
              (s.st == ST_FAIL) || ((s.st == ST_HWRST) && s.hw_busy);
  endfunction : is_busy

  logic req;
  logic acc;
  logic sec_sel;
  logic [7:0] fbyte;
  logic [7:0] d;
  state_e ret;

  // next state
  always_comb begin
    r_next = r_reg;
    req = avs_read | avs_write;
    acc = req & ~r_reg.waitreq;
    d = avs_writedata[7:0];
    sec_sel = r_reg.sel[sector_of(r_reg.addr)];
    ret = r_reg.susp ? ST_SUSP : ST_READ;

    // data seen at a flash read
    fbyte = r_reg.mem[r_reg.addr[3:0]];
    case (r_reg.st)
      ST_AUTOSEL: fbyte = `AUTOSEL_CODE;
      ST_PROGRAM, ST_FAIL: begin
        fbyte = 8'h00;
        fbyte[7] = ~r_reg.pd[7];
        fbyte[6] = r_reg.tog;
        fbyte[5] = r_reg.tl;
        fbyte[2] = r_reg.stog;
      end
      ST_ERASE_WIN, ST_ERASE: begin
        fbyte = 8'h00;
        fbyte[6] = r_reg.tog;
        fbyte[5] = r_reg.tl;
        fbyte[3] = r_reg.ew;
        fbyte[2] = r_reg.stog;
      end
      ST_SUSP: begin
        if (sec_sel) begin
          fbyte = 8'h80;
          fbyte[6] = r_reg.tog;
          fbyte[2] = r_reg.stog;
        end
      end
      default: ;
    endcase

    // bus handshake: one wait cycle, then answer
    r_next.waitreq = ~(req & r_reg.waitreq);
    if (avs_read && r_reg.waitreq) begin
      case (avs_address)
        `OFS_ADDR: r_next.rdata = {20'h00000, r_reg.addr};
        `OFS_DATA: r_next.rdata = {24'h000000, fbyte};
        `OFS_STATE: r_next.rdata = {20'h00000, is_busy(r_reg), r_reg.susp, r_reg.ew, r_reg.tl,
                                    r_reg.sel, r_reg.st};
        default: r_next.rdata = 32'h00000000;
      endcase
    end

    // bit 6 flips on each accepted data read in program, erase or failure; bit 2 only on reads of a selected sector in erase or suspend
    if (acc && avs_read && avs_address == `OFS_DATA) begin
      if (r_reg.st == ST_PROGRAM || r_reg.st == ST_ERASE_WIN || r_reg.st == ST_ERASE ||
          r_reg.st == ST_FAIL) begin
        r_next.tog = ~r_reg.tog;
      end
      if ((r_reg.st == ST_ERASE_WIN || r_reg.st == ST_ERASE || r_reg.st == ST_SUSP) && sec_sel) begin
        r_next.stog = ~r_reg.stog;
      end
    end

    // embedded operation timers
    case (r_reg.st)
      ST_PROGRAM: begin
        r_next.cnt = r_reg.cnt + 24'h000001;
        if (!r_reg.bad && r_reg.cnt == 24'(`PROG_CYCLES - 1)) begin
          r_next.mem[r_reg.pa] = r_reg.mem[r_reg.pa] & r_reg.pd;
          r_next.st = ret;
        end else if (r_reg.bad && r_reg.cnt == 24'(`LIMIT_CYCLES - 1)) begin
          r_next.tl = 1'b1;
          r_next.st = ST_FAIL;
        end
      end
      ST_ERASE_WIN: begin
        r_next.cnt = r_reg.cnt + 24'h000001;
        if (r_reg.cnt == 24'(ERASE_WIN_CYCLES - 1)) begin
          r_next.ew = 1'b1;
          r_next.st = ST_ERASE;
          r_next.cnt = 24'h000000;
        end
      end
      ST_ERASE: begin
        r_next.cnt = r_reg.cnt + 24'h000001;
        if (r_reg.cnt == 24'(`ERASE_CYCLES - 1)) begin
          for (int i = 0; i < 16; i++) begin
            if (r_reg.sel[i / 4]) begin
              r_next.mem[i] = `ERASED_BYTE;
            end
          end
          r_next.sel = 4'h0;
          r_next.ew = 1'b0;
          r_next.susp = 1'b0;
          r_next.st = ST_READ;
        end
      end
      ST_HWRST: begin
        if (r_reg.cnt != 24'hffffff) begin
          r_next.cnt = r_reg.cnt + 24'h000001;
        end
        if (reset_pin_n && r_reg.cnt >= (r_reg.hw_busy ? 24'(`READY_BUSY_CYCLES) :
                                         24'(`READY_IDLE_CYCLES))) begin
          r_next.st = ST_READ;
          r_next.hw_busy = 1'b0;
        end
      end
      default: ;
    endcase

    // address register write
    if (acc && avs_write && avs_address == `OFS_ADDR) begin
      r_next.addr = avs_writedata[11:0];
    end

    // flash command cycles
    if (acc && avs_write && avs_address == `OFS_DATA) begin
      case (r_reg.st)
        ST_READ, ST_SUSP: begin
          if (d == `CMD_RESET) begin
            r_next.st = ret;
          end else if (r_reg.addr == `CMD_ADDR_UNLOCK1 && d == `CMD_UNLOCK1) begin
            r_next.st = ST_C1;
          end else if (r_reg.st == ST_SUSP && d == `CMD_RESUME) begin
            r_next.st = ST_ERASE;
            r_next.susp = 1'b0;
          end
        end
        ST_C1: r_next.st = (r_reg.addr == `CMD_ADDR_UNLOCK2 && d == `CMD_UNLOCK2) ? ST_C2 : ret;
        ST_C2: begin
          r_next.st = ret;
          if (r_reg.addr == `CMD_ADDR_UNLOCK1) begin
            if (d == `CMD_PROGRAM) r_next.st = ST_PROG_ADDR;
            if (d == `CMD_ERASE_SETUP && !r_reg.susp) r_next.st = ST_E3;
            if (d == `CMD_AUTOSELECT && !r_reg.susp) r_next.st = ST_AUTOSEL;
          end
        end
        ST_PROG_ADDR: begin
          if (d == `CMD_RESET) begin
            r_next.st = ret;
          end else begin
            r_next.pa = r_reg.addr[3:0];
            r_next.pd = d;
            r_next.bad = |(d & ~r_reg.mem[r_reg.addr[3:0]]);
            r_next.cnt = 24'h000000;
            r_next.tl = 1'b0;
            r_next.st = ST_PROGRAM;
          end
        end
        ST_E3: r_next.st = (r_reg.addr == `CMD_ADDR_UNLOCK1 && d == `CMD_UNLOCK1) ? ST_E4 : ST_READ;
        ST_E4: r_next.st = (r_reg.addr == `CMD_ADDR_UNLOCK2 && d == `CMD_UNLOCK2) ? ST_E5 : ST_READ;
        ST_E5: begin
          r_next.st = ST_READ;
          r_next.cnt = 24'h000000;
          r_next.tl = 1'b0;
          if (d == `CMD_SECTOR_ERASE) begin
            r_next.sel[sector_of(r_reg.addr)] = 1'b1;
            r_next.ew = 1'b0;
            r_next.st = ST_ERASE_WIN;
          end else if (d == `CMD_CHIP_ERASE && r_reg.addr == `CMD_ADDR_UNLOCK1) begin
            r_next.sel = 4'hf;
            r_next.ew = 1'b1;
            r_next.st = ST_ERASE;
          end
        end
        ST_AUTOSEL: if (d == `CMD_RESET) r_next.st = ST_READ;
        ST_ERASE_WIN: begin
          // window expiring in the same cycle wins over an added sector
          if (d == `CMD_SECTOR_ERASE && r_next.st == ST_ERASE_WIN) begin
            r_next.sel[sector_of(r_reg.addr)] = 1'b1;
            r_next.cnt = 24'h000000;
            r_next.ew = 1'b0;
            r_next.st = ST_ERASE_WIN;
          end else if (d == `CMD_SUSPEND) begin
            r_next.ew = 1'b1;
            r_next.susp = 1'b1;
            r_next.st = ST_SUSP;
          end
        end
        ST_ERASE: begin
          if (d == `CMD_SUSPEND) begin
            r_next.susp = 1'b1;
            r_next.st = ST_SUSP;
          end
        end
        ST_FAIL: begin
          if (d == `CMD_RESET) begin
            r_next.tl = 1'b0;
            r_next.st = ret;
          end
        end
        default: ; // program and hardware reset ignore commands
      endcase
    end

    // hardware reset pin wins over everything
    if (!reset_pin_n && r_reg.st != ST_HWRST) begin
      r_next.hw_busy = is_busy(r_reg);
      r_next.st = ST_HWRST;
      r_next.cnt = 24'h000000;
      r_next.susp = 1'b0;
      r_next.sel = 4'h0;
      r_next.tl = 1'b0;
      r_next.ew = 1'b0;
    end

    r_next.busy_oe_n = ~is_busy(r_next);
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.waitreq <= 1'b1;
      r_reg.st <= ST_READ;
      r_reg.busy_oe_n <= 1'b1;
      r_reg.mem <= {16{`ERASED_BYTE}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata = r_reg.rdata;
  assign avs_waitrequest = r_reg.waitreq;
  assign busy_indicator_n_o = 1'b0; // open drain only ever pulls low
  assign busy_indicator_n_oe_n = r_reg.busy_oe_n;

endmodule : flash_write_status_and_reset_cmd

// file: tb/busy_line_pullup.sv
// Purpose: pull-up on the open-drain busy line
// Assumes: one driver on the line
// Notes: released line reads high
`timescale 1ns/1ps
module busy_line_pullup (
  input wire logic drv_o, // driven level
  input wire logic drv_oe_n, // low while pulling
  output logic line // resolved level
);
  // released line floats up to one
  assign line = drv_oe_n ? 1'b1 : drv_o;
endmodule : busy_line_pullup

// file: tb/flash_status_chk.sv
// Purpose: bus timing and busy pin checks
// Assumes: top module ports only
// Notes: bound below
`timescale 1ns/1ps
module flash_status_chk (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic [4:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic reset_pin_n, // reset pin
  input wire logic busy_indicator_n_o, // pin level
  input wire logic busy_indicator_n_oe_n // pin enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic wr_ok;
  // accepted command write
  assign wr_ok = avs_write && !avs_waitrequest && avs_address == 5'h04;
  // pending request and its one-cycle answer
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_one: assert property (req_wait |=> one_ack)
    else $error("request not answered after one wait");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_pin_low: assert property (busy_indicator_n_o == 1'b0)
    else $error("busy pin drives high");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h08 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_busy_cause: assert property ($fell(busy_indicator_n_oe_n) |-> $past(wr_ok) || $past(wr_ok, 2))
    else $error("busy without command write");
  a_hw_hold: assert property (!reset_pin_n && !busy_indicator_n_oe_n |=> !busy_indicator_n_oe_n)
    else $error("busy released during reset pin");
  a_hw_idle: assert property (!reset_pin_n && !$past(reset_pin_n) && busy_indicator_n_oe_n |=> busy_indicator_n_oe_n)
    else $error("idle reset pin made busy");
  a_rd_quiet: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data changed without read");
endmodule : flash_status_chk
bind flash_write_status_and_reset_cmd flash_status_chk u_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .reset_pin_n(reset_pin_n), .busy_indicator_n_o(busy_indicator_n_o),
  .busy_indicator_n_oe_n(busy_indicator_n_oe_n));

// file: tb/flash_write_status_and_reset_cmd_bench.sv
// Purpose: self-checking bench of the flash status sequencer
// Assumes: short erase window
// Notes: reads checked by a queue-fed monitor
`timescale 1ns/1ps
`include "flash_status_defines.svh"
module flash_write_status_and_reset_cmd_bench;
  localparam int WIN = 60;
  logic clk = 0, srst = 1, avs_read = 0, avs_write = 0, reset_pin_n = 1;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd_last, e, m;
  logic avs_waitrequest, bo, boe, pin, tg;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] lf = 16'd32876;
  logic [7:0] d;
  logic [11:0] a;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  flash_write_status_and_reset_cmd #(.ERASE_WIN_CYCLES(WIN)) dut (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reset_pin_n(reset_pin_n),
    .busy_indicator_n_o(bo), .busy_indicator_n_oe_n(boe));
  busy_line_pullup u_pull (.drv_o(bo), .drv_oe_n(boe), .line(pin));
  // clock
  initial begin
    forever #2 clk = ~clk;
  end
  // next value of the stimulus register
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check(input logic [31:0] s, input logic [31:0] w, input string n);
    samples_checked++;
    if (s !== w) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, w, s);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // one bus transfer, held until accepted
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [4:0] ad, input logic [31:0] ev, input logic [31:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    bus(1'b0, ad, {lf, lf});
  endtask : rd
  task automatic cmd(input logic [11:0] ca, input logic [7:0] cd);
    bus(1'b1, `OFS_ADDR, {20'h0, ca});
    bus(1'b1, `OFS_DATA, {24'h0, cd});
  endtask : cmd
  task automatic unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_UNLOCK1);
    cmd(`CMD_ADDR_UNLOCK2, `CMD_UNLOCK2);
  endtask : unlock
  task automatic wait_idle;
    do rd(`OFS_STATE, 0, 0); while (rd_last[11] !== 1'b0);
  endtask : wait_idle
  // monitor: oldest note against each read answer
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      rd_last = avs_readdata;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 0) check(avs_readdata & m, e, "read");
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(`OFS_STATE, 0, 32'h90f);
    rd(5'h1c, 0, 32'hffffffff);
    lf = lfsr_next(lf);
    d = lf[7:0] & 8'hfe;
    a = {8'h0, lf[11:8]};
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_PROGRAM);
    check(pin, 1, "pin");
    cmd(a, d);
    @(posedge clk);
    check(pin, 0, "pin");
    rd(`OFS_DATA, {24'h0, ~d[7], 7'h0}, 32'ha0);
    tg = rd_last[6];
    rd(`OFS_DATA, 0, 0);
    check(rd_last[6] ^ tg, 1, "toggle");
    wait_idle;
    rd(`OFS_DATA, {24'h0, d}, 32'hff);
    // raise a zero bit: fails on limit
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_PROGRAM);
    cmd(a, 8'hff);
    repeat (1100) @(posedge clk);
    rd(`OFS_STATE, 32'h100, 32'h100);
    rd(`OFS_DATA, 32'h20, 32'h20);
    cmd(lf[15:4], `CMD_RESET);
    rd(`OFS_STATE, 0, 32'h90f);
    // reset inside a sequence
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_RESET);
    rd(`OFS_STATE, 0, 32'hf);
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_ERASE_SETUP);
    unlock;
    cmd(12'h0, `CMD_RESET);
    rd(`OFS_STATE, 0, 32'hf);
    // autoselect, left only by a reset command
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_AUTOSELECT);
    rd(`OFS_DATA, {24'h0, `AUTOSEL_CODE}, 32'hff);
    cmd(12'h0, `CMD_RESET);
    rd(`OFS_STATE, 0, 32'hf);
    // sector erase, added sector restarts the window
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_ERASE_SETUP);
    unlock;
    cmd(12'h004, `CMD_SECTOR_ERASE);
    repeat (40) @(posedge clk);
    cmd(12'h008, `CMD_SECTOR_ERASE);
    repeat (20) @(posedge clk);
    rd(`OFS_STATE, 32'h869, 32'ha6f);
    repeat (WIN) @(posedge clk);
    rd(`OFS_STATE, 32'ha6a, 32'ha6f);
    rd(`OFS_DATA, 32'h08, 32'h88);
    cmd(12'h008, `CMD_RESET);
    rd(`OFS_STATE, 32'ha6a, 32'ha6f);
    cmd(12'h008, `CMD_SUSPEND);
    @(posedge clk);
    check(pin, 1, "pin");
    rd(`OFS_DATA, 32'h80, 32'ha0);
    cmd(12'h008, `CMD_RESET);
    rd(`OFS_STATE, 32'h400, 32'hc00);
    cmd(12'h008, `CMD_RESUME);
    wait_idle;
    rd(`OFS_DATA, 32'hff, 32'hff);
    // chip erase: busy only after the sixth write
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_ERASE_SETUP);
    unlock;
    check(pin, 1, "pin");
    cmd(`CMD_ADDR_UNLOCK1, `CMD_CHIP_ERASE);
    @(posedge clk);
    check(pin, 0, "pin");
    wait_idle;
    rd(`OFS_DATA, 32'hff, 32'hff);
    // reset pin during program, then while idle
    unlock;
    cmd(`CMD_ADDR_UNLOCK1, `CMD_PROGRAM);
    cmd(a, 8'h00);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(pin, 0, "pin");
    reset_pin_n <= 1'b1;
    wait_idle;
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(pin, 1, "pin");
    reset_pin_n <= 1'b1;
    wait_idle;
    // idle recovery runs on without showing busy
    repeat (`READY_IDLE_CYCLES) @(posedge clk);
    rd(`OFS_STATE, 0, 32'hf);
    tally_and_finish;
  end
endmodule : flash_write_status_and_reset_cmd_bench
